// *** dv/tb.sv ***
// self-checking bench for the uart interrupt, baud and dma-ready block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out, q;
  logic        pready_out, pslverr_out, err, rxs, txp_in;
  logic        b16, bt, irq_out, rxp, txp;
  int          mismatches = 0;
  int          n_checks = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  uib_core dut (.clk_sys_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rx_stop_center_in(rxs),
    .tx_pop_in(txp_in), .baud16_tick_out(b16), .baud_tick_out(bt), .irq_out,
    .rx_dma_ready_pin_out(rxp), .tx_dma_ready_pin_out(txp));
  uib_peer peer (.clk_sys_in, .rx_stop_center_out(rxs), .tx_pop_out(txp_in));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // request held until the edge that samples pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    q = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) hang();
  endtask
  task automatic interrupt_status_reg(input logic [7:0] e);
    apb(12'h004, 1'b0, 32'h0);
    chk(q, {24'h0, e});
  endtask
  task automatic tick(inout int c, inout int h);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      c++;
      n++;
      if (b16 === 1'b1) h++;
    end while (bt !== 1'b1 && n < 3000);
    if (n >= 3000) hang();
  endtask
  task automatic t_reset();
    chkb(irq_out, 1'b0);
    chkb(rxp, 1'b1);
    chkb(txp, 1'b0);
    apb(12'h000, 1'b1, 32'h2);
    wt(2);
    chkb(irq_out, 1'b1);
    interrupt_status_reg(8'h02);
    wt(2);
    chkb(irq_out, 1'b0);
    apb(12'h03c, 1'b0, 32'h0);
    chkb(err, 1'b1);
    chk(q, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_tx();
    apb(12'h01c, 1'b1, 32'h1);
    apb(12'h034, 1'b1, 32'h5a);
    wt(2);
    chkb(txp, 1'b1);
    peer.pulse(1'b1, 1, 0);
    wt(2);
    chkb(txp, 1'b0);
    $display("test tx done");
  endtask
  task automatic t_rx();
    apb(12'h000, 1'b1, 32'h3);
    peer.pulse(1'b0, 8, 1);
    interrupt_status_reg(8'h04);
    apb(12'h008, 1'b0, 32'h0);
    chkb(q[0], 1'b1);
    wt(600);
    interrupt_status_reg(8'h04);
    wt(50);
    interrupt_status_reg(8'h0c);
    apb(12'h030, 1'b0, 32'h0);
    wt(600);
    interrupt_status_reg(8'h02);
    wt(50);
    interrupt_status_reg(8'h0c);
    repeat (7) apb(12'h030, 1'b0, 32'h0);
    apb(12'h008, 1'b0, 32'h0);
    chkb(q[0], 1'b0);
    chkb(rxp, 1'b1);
    wt(700);
    interrupt_status_reg(8'h01);
    $display("test rx done");
  endtask
  // 5 data bits, parity, 1.5 stop: 17 half bits, 544 ticks for four characters
  task automatic t_lcr();
    apb(12'h038, 1'b1, 32'hc);
    peer.pulse(1'b0, 1, 0);
    wt(520);
    interrupt_status_reg(8'h01);
    wt(40);
    interrupt_status_reg(8'h0c);
    apb(12'h030, 1'b0, 32'h0);
    apb(12'h038, 1'b1, 32'h3);
    $display("test lcr done");
  endtask
  task automatic t_dma();
    apb(12'h01c, 1'b1, 32'h9);
    peer.pulse(1'b0, 1, 0);
    wt(2);
    chkb(rxp, 1'b1);
    wt(700);
    chkb(rxp, 1'b0);
    peer.pulse(1'b0, 7, 3);
    repeat (8) apb(12'h030, 1'b0, 32'h0);
    wt(2);
    chkb(rxp, 1'b1);
    peer.pulse(1'b0, 8, 0);
    wt(2);
    chkb(rxp, 1'b0);
    repeat (8) apb(12'h030, 1'b0, 32'h0);
    for (int s = 32; s <= 128; s += 96) begin
      if (s == 128) apb(12'h020, 1'b1, 32'h1);
      repeat (s - 1) apb(12'h034, 1'b1, 32'h0);
      wt(2);
      chkb(txp, 1'b0);
      apb(12'h034, 1'b1, 32'h0);
      wt(2);
      chkb(txp, 1'b1);
      peer.pulse(1'b1, 1, 0);
      wt(2);
      chkb(txp, 1'b0);
      peer.pulse(1'b1, s - 1, 0);
    end
    $display("test dma done");
  endtask
  task automatic t_baud();
    int nd[3] = '{3, 1, 2};
    int mf[3] = '{0, 8, 0};
    int pr[3] = '{1, 1, 4};
    int c;
    int h;
    for (int i = 0; i < 3; i++) begin
      apb(12'h00c, 1'b1, 32'(nd[i]));
      apb(12'h010, 1'b1, 32'h0);
      apb(12'h014, 1'b1, 32'(mf[i]));
      apb(12'h018, 1'b1, (pr[i] == 4) ? 32'h80 : 32'h0);
      tick(c, h);
      tick(c, h);
      c = 0;
      h = 0;
      repeat (4) tick(c, h);
      chk(32'(c), 32'(4 * pr[i] * (16 * nd[i] + mf[i])));
      chk(32'(h), 32'd64);
    end
    $display("test baud done");
  endtask
  initial begin
    wt(6);
    rst_n_in <= 1'b1;
    wt(1);
    t_reset();
    t_tx();
    t_rx();
    t_lcr();
    t_dma();
    t_baud();
    complete_run();
  end
endmodule // tb

// *** dv/uib_core_props.sv ***
// port-level assertions for the uart interrupt, baud and dma-ready block
module uib_core_props (
  // clock, reset and apb
  input logic        clk_sys_in,
  input logic        rst_n_in,
  input logic        psel_in,
  input logic        penable_in,
  input logic        pwrite_in,
  input logic [11:0] paddr_in,
  input logic [31:0] pwdata_in,
  input logic [31:0] prdata_out,
  input logic        pready_out,
  input logic        pslverr_out,
  // datapath events and outputs
  input logic        rx_stop_center_in,
  input logic        tx_pop_in,
  input logic        baud16_tick_out,
  input logic        baud_tick_out,
  input logic        irq_out,
  input logic        rx_dma_ready_pin_out,
  input logic        tx_dma_ready_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic dma;
  // mirror of the dma mode bit, taken from committed fifo-control writes
  always_ff @(posedge clk_sys_in)
    if (!rst_n_in)
      dma <= 1'b0;
    else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h01c)
      dma <= pwdata_in[3];
  sequence setup_s; psel_in && !penable_in; endsequence
  sequence answer_s; !pready_out ##1 pready_out; endsequence
  ready_timing_a: assert property (setup_s |=> answer_s) else $error("pready timing");
  ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("pready held");
  err_ready_a: assert property (pslverr_out |-> pready_out) else $error("stray pslverr");
  err_zero_a: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("error read data");
  baud_gap_a: assert property (baud_tick_out |=> !baud_tick_out [*8])
    else $error("baud ticks too close");
  reset_pins_a: assert property ($rose(rst_n_in) |-> rx_dma_ready_pin_out
    && !tx_dma_ready_pin_out && !irq_out) else $error("reset levels");
  rx_rise_a: assert property ($rose(rx_dma_ready_pin_out) && !dma |-> $past(pready_out))
    else $error("rx ready rose without access");
  rx_fall_a: assert property ($fell(rx_dma_ready_pin_out) && !dma
    |-> $past(rx_stop_center_in) || $past(pready_out)) else $error("rx ready fell alone");
  tx_rise_a: assert property ($rose(tx_dma_ready_pin_out) |-> $past(pready_out))
    else $error("tx ready rose without write");
  tx_fall_a: assert property ($fell(tx_dma_ready_pin_out)
    |-> $past(tx_pop_in) || $past(pready_out)) else $error("tx ready fell alone");
endmodule // uib_core_props
bind uib_core uib_core_props chk_i (.clk_sys_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rx_stop_center_in, .tx_pop_in,
  .baud16_tick_out, .baud_tick_out, .irq_out, .rx_dma_ready_pin_out, .tx_dma_ready_pin_out);

// *** dv/uib_peer.sv ***
// serial-side peer: reports received stop-bit centres and takes tx bytes
module uib_peer (
  // clock
  input  logic clk_sys_in,
  // datapath events
  output logic rx_stop_center_out,
  output logic tx_pop_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_stop_center_out = 1'b0;
    tx_pop_out = 1'b0;
  end
  // one-cycle events; gap lets the peer run fast or slow
  task automatic pulse(input logic tx, input int n, input int gap);
    repeat (n) begin
      @(posedge clk_sys_in);
      rx_stop_center_out <= !tx;
      tx_pop_out <= tx;
      @(posedge clk_sys_in);
      rx_stop_center_out <= 1'b0;
      tx_pop_out <= 1'b0;
      repeat (gap) @(posedge clk_sys_in);
    end
  endtask
endmodule // uib_peer

// *** hw/uib_core.v ***
// uart interrupt priority, receive time-out, rational baud generator, dma ready pins
`include "uib_defs.vh"

module uib_core (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // serial datapath events
  input  wire        rx_stop_center_in,
  input  wire        tx_pop_in,
  // timing and status out
  output reg         baud16_tick_out,
  output reg         baud_tick_out,
  output reg         irq_out,
  output reg         rx_dma_ready_pin_out,
  output reg         tx_dma_ready_pin_out
);

  // software registers
  reg  [7:0]  interrupt_enable_reg;
  reg  [7:0]  divisor_low_byte;
  reg  [7:0]  divisor_high_byte;
  reg  [3:0]  fractional_prescale;
  reg  [7:0]  modem_control_reg;
  reg  [7:0]  fifo_control_reg;
  reg  [7:0]  tx_trigger_level;
  reg  [7:0]  rx_trigger_level;
  reg  [7:0]  flow_high_level;
  reg  [7:0]  flow_low_level;
  reg  [3:0]  line_ctrl_reg;
  // block state
  reg  [7:0]  rx_count;
  reg  [7:0]  tx_count;
  reg         thre_pending;
  reg         timeout_flag;
  reg         overrun_flag;
  reg  [9:0]  timeout_cnt;
  reg  [1:0]  pre_cnt;
  reg  [20:0] frac_acc;
  reg  [3:0]  tick16_cnt;
  reg         ext_mode_q;
  reg         fifo_en_q;
  // combinational
  wire        apb_access;
  wire        apb_do;
  wire        wr_do;
  wire        rd_do;
  wire        ext_mode;
  wire [7:0]  fifo_cap;
  reg  [7:0]  rx_trig;
  wire        size_change;
  wire        rhr_read;
  wire        isr_read;
  wire        lsr_read;
  wire        thr_write;
  wire        rx_push;
  wire        rx_pop;
  wire        tx_push;
  wire        tx_pop;
  reg  [7:0]  next_rx_count;
  reg  [7:0]  next_tx_count;
  wire        rx_int;
  wire        to_int;
  wire        thre_int;
  reg  [7:0]  isr_code;
  wire [15:0] divisor_n;
  wire [20:0] divisor_full;
  wire        pre_en;
  wire [20:0] acc_sum;
  reg  [5:0]  char_bits2;
  wire [9:0]  timeout_limit;
  reg  [31:0] rd_mux;
  reg         addr_ok;

  assign apb_access = psel_in & penable_in;
  // one wait state: pready is a flop, so the action edge is the second access edge
  assign apb_do     = apb_access & pready_out;
  assign wr_do      = apb_do & pwrite_in & addr_ok;
  assign rd_do      = apb_do & ~pwrite_in & addr_ok;
  assign rhr_read   = rd_do & (paddr_in == `UIB_OFS_RHR);
  assign isr_read   = rd_do & (paddr_in == `UIB_OFS_ISR);
  assign lsr_read   = rd_do & (paddr_in == `UIB_OFS_LSR);
  assign thr_write  = wr_do & (paddr_in == `UIB_OFS_THR);

  // fifo size
  assign ext_mode = (tx_trigger_level != 8'h00) | (rx_trigger_level != 8'h00) |
                    (flow_high_level != 8'h00) | (flow_low_level != 8'h00);
  assign fifo_cap = ext_mode ? `UIB_FIFO_EXT : `UIB_FIFO_NORMAL;
  // switching effective size or fifo enable empties both fifos
  assign size_change = (ext_mode != ext_mode_q) |
                       (fifo_control_reg[`UIB_FCR_EN_BIT] != fifo_en_q);

  always @* begin
    if (ext_mode) begin
      rx_trig = rx_trigger_level;
    end else begin
      case (fifo_control_reg[7:6])
        2'b00:   rx_trig = `UIB_RX_TRIG_0;
        2'b01:   rx_trig = `UIB_RX_TRIG_1;
        2'b10:   rx_trig = `UIB_RX_TRIG_2;
        default: rx_trig = `UIB_RX_TRIG_3;
      endcase
    end
  end

  // receive push past full is dropped and flagged as overrun; transmit push past full is dropped
  assign rx_push = rx_stop_center_in & (rx_count < fifo_cap);
  assign rx_pop  = rhr_read & (rx_count != 8'h00);
  assign tx_push = thr_write & (tx_count < fifo_cap);
  assign tx_pop  = tx_pop_in & (tx_count != 8'h00);

  always @* begin
    next_rx_count = rx_count;
    next_tx_count = tx_count;
    if (size_change) begin
      next_rx_count = 8'h00;
      next_tx_count = 8'h00;
    end else begin
      if (rx_push & ~rx_pop) begin
        next_rx_count = rx_count + 8'h01;
      end else if (rx_pop & ~rx_push) begin
        next_rx_count = rx_count - 8'h01;
      end
      if (tx_push & ~tx_pop) begin
        next_tx_count = tx_count + 8'h01;
      end else if (tx_pop & ~tx_push) begin
        next_tx_count = tx_count - 8'h01;
      end
    end
  end

  // interrupt sources
  assign rx_int   = interrupt_enable_reg[`UIB_IER_RX_BIT] &
                    (rx_count >= rx_trig) & (rx_count != 8'h00);
  assign to_int   = interrupt_enable_reg[`UIB_IER_RX_BIT] & timeout_flag;
  assign thre_int = interrupt_enable_reg[`UIB_IER_THRE_BIT] & thre_pending;

  // only the top pending source is visible
  always @* begin
    if (to_int) begin
      isr_code = `UIB_ISR_TIMEOUT;
    end else if (rx_int) begin
      isr_code = `UIB_ISR_RXDATA;
    end else if (thre_int) begin
      isr_code = `UIB_ISR_THRE;
    end else begin
      isr_code = `UIB_ISR_NONE;
    end
  end

  // baud generator: accumulator adds 16 per prescaled clock, wraps at 16n+m
  assign divisor_n    = {divisor_high_byte, divisor_low_byte};
  assign divisor_full = {1'b0, divisor_n, fractional_prescale};
  assign pre_en       = modem_control_reg[`UIB_MCR_PRE4_BIT] ?
                        (pre_cnt == `UIB_PRESCALE_SLOW) : 1'b1;
  assign acc_sum      = frac_acc + {16'h0000, `UIB_TICKS_PER_BIT};

  // character length in half bits: start + data + parity, then stop
  always @* begin
    char_bits2 = {1'b0, 4'd6 + {2'b00, line_ctrl_reg[1:0]}, 1'b0}
                 + {4'h0, line_ctrl_reg[`UIB_LCR_PAR_BIT], 1'b0};
    if (!line_ctrl_reg[`UIB_LCR_STOP_BIT]) begin
      char_bits2 = char_bits2 + 6'd2;
    end else if (line_ctrl_reg[1:0] == 2'b00) begin
      char_bits2 = char_bits2 + 6'd3;
    end else begin
      char_bits2 = char_bits2 + 6'd4;
    end
  end
  // 4 chars * half bits * 8 ticks per half bit
  assign timeout_limit = {1'b0, char_bits2, 3'b000} * `UIB_TIMEOUT_CHARS;

  // register read mux
  always @* begin
    rd_mux  = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_in)
      `UIB_OFS_IER:     rd_mux[7:0] = interrupt_enable_reg;
      `UIB_OFS_ISR:     rd_mux[7:0] = isr_code;
      `UIB_OFS_LSR: begin
        rd_mux[`UIB_LSR_DR_BIT]   = (rx_count != 8'h00);
        rd_mux[`UIB_LSR_OVR_BIT]  = overrun_flag;
        rd_mux[`UIB_LSR_THRE_BIT] = (tx_count == 8'h00);
      end
      `UIB_OFS_DIV_LO:  rd_mux[7:0] = divisor_low_byte;
      `UIB_OFS_DIV_HI:  rd_mux[7:0] = divisor_high_byte;
      `UIB_OFS_FRAC:    rd_mux[3:0] = fractional_prescale;
      `UIB_OFS_MCR:     rd_mux[7:0] = modem_control_reg;
      `UIB_OFS_FCR:     rd_mux[7:0] = fifo_control_reg;
      `UIB_OFS_TX_TRIG: rd_mux[7:0] = tx_trigger_level;
      `UIB_OFS_RX_TRIG: rd_mux[7:0] = rx_trigger_level;
      `UIB_OFS_FLOW_HI: rd_mux[7:0] = flow_high_level;
      `UIB_OFS_FLOW_LO: rd_mux[7:0] = flow_low_level;
      `UIB_OFS_RHR:     rd_mux[7:0] = rx_count;
      `UIB_OFS_THR:     rd_mux[7:0] = tx_count;
      `UIB_OFS_LCR:     rd_mux[3:0] = line_ctrl_reg;
      default:          addr_ok = 1'b0;
    endcase
  end

  // apb and register writes
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pready_out           <= 1'b0;
      prdata_out           <= 32'h0000_0000;
      pslverr_out          <= 1'b0;
      interrupt_enable_reg <= `UIB_RST_BYTE;
      divisor_low_byte     <= `UIB_RST_DIV_LO;
      divisor_high_byte    <= `UIB_RST_BYTE;
      fractional_prescale  <= `UIB_RST_FRAC;
      modem_control_reg    <= `UIB_RST_BYTE;
      fifo_control_reg     <= `UIB_RST_BYTE;
      tx_trigger_level     <= `UIB_RST_BYTE;
      rx_trigger_level     <= `UIB_RST_BYTE;
      flow_high_level      <= `UIB_RST_BYTE;
      flow_low_level       <= `UIB_RST_BYTE;
      line_ctrl_reg        <= `UIB_RST_LCR;
    end else begin
      pready_out  <= apb_access & ~pready_out;
      pslverr_out <= apb_access & ~pready_out & ~addr_ok;
      if (apb_access & ~pready_out & ~pwrite_in) begin
        prdata_out <= rd_mux;
      end
      if (wr_do) begin
        case (paddr_in)
          `UIB_OFS_IER:     interrupt_enable_reg <= pwdata_in[7:0];
          `UIB_OFS_DIV_LO:  divisor_low_byte     <= pwdata_in[7:0];
          `UIB_OFS_DIV_HI:  divisor_high_byte    <= pwdata_in[7:0];
          `UIB_OFS_FRAC:    fractional_prescale  <= pwdata_in[3:0];
          `UIB_OFS_MCR:     modem_control_reg    <= pwdata_in[7:0];
          `UIB_OFS_FCR:     fifo_control_reg     <= pwdata_in[7:0];
          `UIB_OFS_TX_TRIG: tx_trigger_level     <= pwdata_in[7:0];
          `UIB_OFS_RX_TRIG: rx_trigger_level     <= pwdata_in[7:0];
          `UIB_OFS_FLOW_HI: flow_high_level      <= pwdata_in[7:0];
          `UIB_OFS_FLOW_LO: flow_low_level       <= pwdata_in[7:0];
          `UIB_OFS_LCR:     line_ctrl_reg        <= pwdata_in[3:0];
          default:          line_ctrl_reg        <= line_ctrl_reg;
        endcase
      end
    end
  end

  // fifo levels, flags, time-out
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rx_count     <= 8'h00;
      tx_count     <= 8'h00;
      thre_pending <= 1'b1;
      timeout_flag <= 1'b0;
      overrun_flag <= 1'b0;
      timeout_cnt  <= 10'h000;
      ext_mode_q   <= 1'b0;
      fifo_en_q    <= 1'b0;
    end else begin
      rx_count   <= next_rx_count;
      tx_count   <= next_tx_count;
      ext_mode_q <= ext_mode;
      fifo_en_q  <= fifo_control_reg[`UIB_FCR_EN_BIT];
      // set wins: transmit fifo draining to empty beats a clear in the same cycle
      if ((next_tx_count == 8'h00) & (tx_count != 8'h00)) begin
        thre_pending <= 1'b1;
      end else if (thr_write | (isr_read & (isr_code == `UIB_ISR_THRE))) begin
        thre_pending <= 1'b0;
      end
      if (rx_stop_center_in & ~rx_push) begin
        overrun_flag <= 1'b1;
      end else if (lsr_read) begin
        overrun_flag <= 1'b0;
      end
      // counter runs only with data waiting, so an empty fifo never times out
      if (rx_stop_center_in | rhr_read | (rx_count == 8'h00)) begin
        timeout_cnt <= 10'h000;
      end else if (baud16_tick_out & (timeout_cnt < timeout_limit)) begin
        timeout_cnt <= timeout_cnt + 10'h001;
      end
      if ((timeout_cnt >= timeout_limit) & (next_rx_count != 8'h00) &
          ~rx_stop_center_in & ~rhr_read) begin
        timeout_flag <= 1'b1;
      end else if (rhr_read | rx_stop_center_in | (next_rx_count == 8'h00)) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // baud generator, shared by transmitter and receiver
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pre_cnt         <= 2'b00;
      frac_acc        <= 21'h000000;
      tick16_cnt      <= 4'h0;
      baud16_tick_out <= 1'b0;
      baud_tick_out   <= 1'b0;
    end else begin
      pre_cnt         <= pre_cnt + 2'b01;
      baud16_tick_out <= 1'b0;
      baud_tick_out   <= 1'b0;
      // a zero integer divisor is outside range: generator stays idle
      if (divisor_n == 16'h0000) begin
        frac_acc <= 21'h000000;
      end else if (pre_en) begin
        if (acc_sum >= divisor_full) begin
          frac_acc        <= acc_sum - divisor_full;
          baud16_tick_out <= 1'b1;
          tick16_cnt      <= tick16_cnt + 4'h1;
          if (tick16_cnt == 4'hf) begin
            baud_tick_out <= 1'b1;
          end
        end else begin
          frac_acc <= acc_sum;
        end
      end
    end
  end

  // interrupt and dma ready pins
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irq_out              <= 1'b0;
      rx_dma_ready_pin_out <= 1'b1;
      tx_dma_ready_pin_out <= 1'b0;
    end else begin
      irq_out <= (isr_code != `UIB_ISR_NONE);
      if (!fifo_control_reg[`UIB_FCR_DMA_BIT]) begin
        rx_dma_ready_pin_out <= (next_rx_count == 8'h00);
        tx_dma_ready_pin_out <= (next_tx_count != 8'h00);
      end else begin
        if (next_rx_count == 8'h00) begin
          rx_dma_ready_pin_out <= 1'b1;
        end else if ((next_rx_count >= rx_trig) | timeout_flag) begin
          rx_dma_ready_pin_out <= 1'b0;
        end
        if (next_tx_count >= fifo_cap) begin
          tx_dma_ready_pin_out <= 1'b1;
        end else begin
          tx_dma_ready_pin_out <= 1'b0;
        end
      end
    end
  end

endmodule // uib_core

// *** hw/uib_defs.vh ***
// constants for the uart interrupt, baud and dma-ready block
`ifndef UIB_DEFS_VH
`define UIB_DEFS_VH

// register byte offsets
`define UIB_OFS_IER        12'h000
`define UIB_OFS_ISR        12'h004
`define UIB_OFS_LSR        12'h008
`define UIB_OFS_DIV_LO     12'h00c
`define UIB_OFS_DIV_HI     12'h010
`define UIB_OFS_FRAC       12'h014
`define UIB_OFS_MCR        12'h018
`define UIB_OFS_FCR        12'h01c
`define UIB_OFS_TX_TRIG    12'h020
`define UIB_OFS_RX_TRIG    12'h024
`define UIB_OFS_FLOW_HI    12'h028
`define UIB_OFS_FLOW_LO    12'h02c
`define UIB_OFS_RHR        12'h030
`define UIB_OFS_THR        12'h034
`define UIB_OFS_LCR        12'h038

// field positions
`define UIB_IER_RX_BIT     0
`define UIB_IER_THRE_BIT   1
`define UIB_MCR_PRE4_BIT   7
`define UIB_FCR_EN_BIT     0
`define UIB_FCR_DMA_BIT    3
`define UIB_LSR_DR_BIT     0
`define UIB_LSR_OVR_BIT    1
`define UIB_LSR_THRE_BIT   5
`define UIB_LCR_STOP_BIT   2
`define UIB_LCR_PAR_BIT    3

// reset values
`define UIB_RST_BYTE       8'h00
`define UIB_RST_DIV_LO     8'h01
`define UIB_RST_FRAC       4'h0
`define UIB_RST_LCR        4'h3

// interrupt status codes
`define UIB_ISR_NONE       8'h01
`define UIB_ISR_THRE       8'h02
`define UIB_ISR_RXDATA     8'h04
`define UIB_ISR_TIMEOUT    8'h0c

// fifo sizes and fixed trigger tables
`define UIB_FIFO_NORMAL    8'd32
`define UIB_FIFO_EXT       8'd128
`define UIB_RX_TRIG_0      8'd8
`define UIB_RX_TRIG_1      8'd16
`define UIB_RX_TRIG_2      8'd24
`define UIB_RX_TRIG_3      8'd28

// timing: 16x ticks per bit, time-out in character times
`define UIB_TICKS_PER_BIT  5'd16
`define UIB_TIMEOUT_CHARS  10'd4
`define UIB_PRESCALE_SLOW  2'd3

`endif
